// ===== rtl/pfm_pkg.sv
package pfm_pkg;
	localparam int PFM_NPINS = 6;
	localparam int PFM_SEL_W = 2;
	localparam logic [PFM_NPINS-1:0] PFM_PER_RST = 6'h00;
	localparam logic [PFM_NPINS-1:0] PFM_DIR_RST = 6'h00;
	localparam logic [PFM_NPINS-1:0] PFM_DATA_RST = 6'h00;
	localparam logic [PFM_SEL_W-1:0] PFM_SEL_RST = 2'h0;
	localparam logic [1:0] PFM_DBG_PER_RST = 2'h3;
	// Pin index within port F group: bit 3 sits at index 0 up to bit 8 at index 5.
	localparam int PFM_F3 = 0;
	localparam int PFM_F4 = 1;
	localparam int PFM_F5 = 2;
	localparam int PFM_F6 = 3;
	localparam int PFM_F7 = 4;
	localparam int PFM_F8 = 5;
	localparam int PFM_PWM_CH = 8;
	localparam int PFM_FAULT_A = 6;
	localparam int PFM_FAULT_B = 7;
	localparam real PFM_CLK_MHZ = 125.0;
	localparam real PFM_IRQ_PULSE_CYC = 1.5;
	localparam int PFM_SYNC_STAGES = 2;
	typedef enum logic [1:0] {
		PFM_ALT0 = 2'h0,
		PFM_ALT1 = 2'h1,
		PFM_ALT2 = 2'h2,
		PFM_ALT3 = 2'h3
	} pfm_alt_e;
	typedef enum logic [1:0] {
		PFM_TST_IDLE = 2'h0,
		PFM_TST_SHIFT_IR = 2'h1,
		PFM_TST_SHIFT_DR = 2'h3,
		PFM_TST_OTHER = 2'h2
	} pfm_tst_e;
endpackage

// ===== rtl/pfm_sync.sv
`timescale 1ns/1ps
module pfm_sync import pfm_pkg::*; #(
	parameter int WIDTH = PFM_NPINS
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_next;

	always_comb begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// Pads idle high on their pull-ups, so both stages start there.
			meta_reg <= '1;
			sync_reg <= '1;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule // pfm_sync

// ===== rtl/pfm_irq.sv
`timescale 1ns/1ps
module pfm_irq import pfm_pkg::*; #(
	parameter int WIDTH = PFM_NPINS
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Synchronised pin levels and control
	input wire logic [WIDTH-1:0] level_in,
	input wire logic [WIDTH-1:0] port_mode_in,
	input wire logic [WIDTH-1:0] enable_in,
	input wire logic [WIDTH-1:0] polarity_in,
	input wire logic [WIDTH-1:0] clear_in,
	// Sticky pending flags
	output logic [WIDTH-1:0] pending_out
);
	logic [WIDTH-1:0] last_reg;
	logic [WIDTH-1:0] last_next;
	logic [WIDTH-1:0] pend_reg;
	logic [WIDTH-1:0] pend_next;
	logic [WIDTH-1:0] edge_hit;

	always_comb begin
		last_next = level_in;
		for (int i = 0; i < WIDTH; i++) begin
			// Polarity set picks the falling edge, clear picks the rising edge.
			edge_hit[i] = polarity_in[i] ? (last_reg[i] & ~level_in[i])
				: (~last_reg[i] & level_in[i]);
		end
		edge_hit = edge_hit & enable_in & port_mode_in;
		// A new edge in the clearing cycle wins so no event is lost.
		pend_next = (pend_reg & ~clear_in) | edge_hit;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			// Matches the pulled-up idle level so release of reset is not an edge.
			last_reg <= '1;
			pend_reg <= '0;
		end else begin
			last_reg <= last_next;
			pend_reg <= pend_next;
		end
	end

	assign pending_out = pend_reg;
endmodule // pfm_irq

// ===== rtl/pfm_mux.sv
`timescale 1ns/1ps
module pfm_mux import pfm_pkg::*; #(
	parameter int NPINS = PFM_NPINS
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Port F configuration, written by software
	input wire logic [NPINS-1:0] port_peripheral_enable_in,
	input wire logic [NPINS*PFM_SEL_W-1:0] pin_peripheral_select_in,
	input wire logic [NPINS-1:0] dir_wr_in,
	input wire logic [NPINS-1:0] dir_val_in,
	input wire logic [NPINS-1:0] data_wr_in,
	input wire logic [NPINS-1:0] data_val_in,
	input wire logic [NPINS-1:0] pin_interrupt_enable_in,
	input wire logic [NPINS-1:0] pin_interrupt_polarity_in,
	input wire logic [NPINS-1:0] irq_clear_in,
	// Port D test pins configuration
	input wire logic [1:0] dbg_peripheral_enable_in,
	input wire logic [1:0] dbg_dir_in,
	input wire logic [1:0] dbg_data_in,
	// Port F pads
	input wire logic [NPINS-1:0] pad_f_in,
	output logic [NPINS-1:0] pad_f_out,
	output logic [NPINS-1:0] pad_f_oe_n_out,
	output logic [NPINS-1:0] pad_f_pullup_out,
	// Port D pads, bit 0 test data in, bit 1 test data out
	input wire logic [1:0] pad_d_in,
	output logic [1:0] pad_d_out,
	output logic [1:0] pad_d_oe_n_out,
	output logic [1:0] pad_d_pullup_out,
	// Test controller
	input wire logic test_clk_in,
	input wire logic [1:0] test_state_in,
	input wire logic test_data_out_in,
	output logic test_data_in_out,
	// Peripherals
	input wire logic twowire0_data_low_in,
	input wire logic [10:7] crossbar_out_in,
	input wire logic serperiph1_master_in,
	input wire logic serperiph1_data_in,
	output logic serperiph1_ctrl_out_periph_in_out,
	output logic serperiph1_select_n_out,
	input wire logic serial1_transmit_in,
	input wire logic serial1_single_wire_in,
	input wire logic serial1_tx_enable_in,
	output logic serial1_receive_out,
	output logic serial0_receive_out,
	input wire logic [PFM_PWM_CH-1:0] pwm_out_in,
	input wire logic [3:0] pwm_capture_mode_in,
	output logic [3:0] pwm_capture_out,
	output logic [PFM_PWM_CH-1:0] pwm_out_out,
	output logic [3:2] crossbar_input_out,
	input wire logic comparator_c_output_in,
	input wire logic comparator_d_output_in,
	// Port status
	output logic [NPINS-1:0] port_read_out,
	output logic [NPINS-1:0] irq_pending_out,
	output logic irq_out
);
	logic [NPINS-1:0] dir_reg, dir_next;
	logic [NPINS-1:0] data_reg, data_next;
	logic [NPINS-1:0] f_sync;
	logic [NPINS-1:0] f_pend;
	logic [1:0] d_sync;
	logic [NPINS-1:0] f_o, f_oe, f_port;
	logic [NPINS-1:0] f_o_reg, f_oe_n_reg, f_pu_reg;
	logic [1:0] d_o, d_oe;
	logic [1:0] d_o_reg, d_oe_n_reg, d_pu_reg;
	logic tdi_s1_reg, tdi_reg;
	logic tdo_reg, tdo_en_reg;
	logic [PFM_PWM_CH-1:0] pwm_reg, pwm_next;
	logic mosi_reg, ss_reg, serial1_receive_reg, rxd0_reg, irq_reg;
	logic [3:0] cap_reg, cap_next;
	logic [3:2] xbin_reg;
	logic mosi_next, ss_next, serial1_receive_next, rxd0_next;
	logic [3:2] xbin_next;

	function automatic logic [PFM_SEL_W-1:0] sel_of(input int idx,
			input logic [NPINS*PFM_SEL_W-1:0] v);
		sel_of = v[idx*PFM_SEL_W +: PFM_SEL_W];
	endfunction

	function automatic logic alt_is(input int idx, input pfm_alt_e a,
			input logic [NPINS-1:0] en, input logic [NPINS*PFM_SEL_W-1:0] v);
		alt_is = en[idx] && (sel_of(idx, v) == a);
	endfunction

	pfm_sync #(.WIDTH(NPINS)) u_sync_f (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(pad_f_in),
		.sync_out(f_sync)
	);

	pfm_sync #(.WIDTH(2)) u_sync_d (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.async_in(pad_d_in),
		.sync_out(d_sync)
	);

	pfm_irq #(.WIDTH(NPINS)) u_irq (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.level_in(f_sync),
		.port_mode_in(~port_peripheral_enable_in),
		.enable_in(pin_interrupt_enable_in),
		.polarity_in(pin_interrupt_polarity_in),
		.clear_in(irq_clear_in),
		.pending_out(f_pend)
	);

	always_comb begin
		dir_next = (dir_reg & ~dir_wr_in) | (dir_val_in & dir_wr_in);
		data_next = (data_reg & ~data_wr_in) | (data_val_in & data_wr_in);
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			dir_reg <= PFM_DIR_RST;
			data_reg <= PFM_DATA_RST;
		end else begin
			dir_reg <= dir_next;
			data_reg <= data_next;
		end
	end

	always_comb begin
		f_port = ~port_peripheral_enable_in;
		for (int i = 0; i < NPINS; i++) begin
			f_o[i] = data_reg[i];
			f_oe[i] = dir_reg[i];
		end
		if (alt_is(PFM_F3, PFM_ALT0, port_peripheral_enable_in, pin_peripheral_select_in)) begin
			// Open drain: pull low only.
			f_o[PFM_F3] = 1'b0;
			f_oe[PFM_F3] = twowire0_data_low_in;
		end else if (alt_is(PFM_F3, PFM_ALT1, port_peripheral_enable_in,
				pin_peripheral_select_in)) begin
			f_o[PFM_F3] = crossbar_out_in[7];
			f_oe[PFM_F3] = 1'b1;
		end else if (port_peripheral_enable_in[PFM_F3]) begin
			f_o[PFM_F3] = serperiph1_data_in;
			f_oe[PFM_F3] = serperiph1_master_in;
		end
		if (alt_is(PFM_F4, PFM_ALT0, port_peripheral_enable_in, pin_peripheral_select_in)) begin
			f_o[PFM_F4] = serial1_transmit_in;
			f_oe[PFM_F4] = ~serial1_single_wire_in | serial1_tx_enable_in;
		end else if (alt_is(PFM_F4, PFM_ALT1, port_peripheral_enable_in,
				pin_peripheral_select_in)) begin
			f_o[PFM_F4] = crossbar_out_in[8];
			f_oe[PFM_F4] = 1'b1;
		end else if (alt_is(PFM_F4, PFM_ALT2, port_peripheral_enable_in,
				pin_peripheral_select_in)) begin
			f_o[PFM_F4] = pwm_reg[0];
			f_oe[PFM_F4] = ~pwm_capture_mode_in[0];
		end else if (port_peripheral_enable_in[PFM_F4]) begin
			f_oe[PFM_F4] = 1'b0;
		end
		if (alt_is(PFM_F5, PFM_ALT1, port_peripheral_enable_in, pin_peripheral_select_in)) begin
			f_o[PFM_F5] = crossbar_out_in[9];
			f_oe[PFM_F5] = 1'b1;
		end else if (alt_is(PFM_F5, PFM_ALT2, port_peripheral_enable_in,
				pin_peripheral_select_in)) begin
			f_o[PFM_F5] = pwm_reg[1];
			f_oe[PFM_F5] = ~pwm_capture_mode_in[1];
		end else if (port_peripheral_enable_in[PFM_F5]) begin
			f_oe[PFM_F5] = 1'b0;
		end
		if (alt_is(PFM_F6, PFM_ALT0, port_peripheral_enable_in, pin_peripheral_select_in)) begin
			f_o[PFM_F6] = pwm_reg[3];
			f_oe[PFM_F6] = ~pwm_capture_mode_in[3];
		end else if (port_peripheral_enable_in[PFM_F6]) begin
			f_oe[PFM_F6] = 1'b0;
		end
		if (alt_is(PFM_F7, PFM_ALT0, port_peripheral_enable_in, pin_peripheral_select_in)) begin
			f_o[PFM_F7] = comparator_c_output_in;
			f_oe[PFM_F7] = 1'b1;
		end else if (port_peripheral_enable_in[PFM_F7]) begin
			f_oe[PFM_F7] = 1'b0;
		end
		if (alt_is(PFM_F8, PFM_ALT1, port_peripheral_enable_in, pin_peripheral_select_in)) begin
			f_o[PFM_F8] = crossbar_out_in[10];
			f_oe[PFM_F8] = 1'b1;
		end else if (alt_is(PFM_F8, PFM_ALT2, port_peripheral_enable_in,
				pin_peripheral_select_in)) begin
			f_o[PFM_F8] = comparator_d_output_in;
			f_oe[PFM_F8] = 1'b1;
		end else if (alt_is(PFM_F8, PFM_ALT3, port_peripheral_enable_in,
				pin_peripheral_select_in)) begin
			f_o[PFM_F8] = pwm_reg[2];
			f_oe[PFM_F8] = ~pwm_capture_mode_in[2];
		end else if (port_peripheral_enable_in[PFM_F8]) begin
			f_oe[PFM_F8] = 1'b0;
		end
	end

	// Peripheral-side inputs from the synchronised pads.
	always_comb begin
		mosi_next = alt_is(PFM_F3, PFM_ALT2, port_peripheral_enable_in,
			pin_peripheral_select_in) & ~serperiph1_master_in & f_sync[PFM_F3];
		ss_next = ~alt_is(PFM_F7, PFM_ALT1, port_peripheral_enable_in,
			pin_peripheral_select_in) | f_sync[PFM_F7];
		serial1_receive_next = alt_is(PFM_F4, PFM_ALT0, port_peripheral_enable_in,
			pin_peripheral_select_in) & serial1_single_wire_in ? f_sync[PFM_F4]
			: (~alt_is(PFM_F5, PFM_ALT0, port_peripheral_enable_in,
			pin_peripheral_select_in) | f_sync[PFM_F5]);
		rxd0_next = ~alt_is(PFM_F8, PFM_ALT0, port_peripheral_enable_in,
			pin_peripheral_select_in) | f_sync[PFM_F8];
		xbin_next[2] = alt_is(PFM_F6, PFM_ALT1, port_peripheral_enable_in,
			pin_peripheral_select_in) & f_sync[PFM_F6];
		xbin_next[3] = alt_is(PFM_F7, PFM_ALT2, port_peripheral_enable_in,
			pin_peripheral_select_in) & f_sync[PFM_F7];
		cap_next[0] = alt_is(PFM_F4, PFM_ALT2, port_peripheral_enable_in,
			pin_peripheral_select_in) & f_sync[PFM_F4];
		cap_next[1] = alt_is(PFM_F5, PFM_ALT2, port_peripheral_enable_in,
			pin_peripheral_select_in) & f_sync[PFM_F5];
		cap_next[2] = alt_is(PFM_F8, PFM_ALT3, port_peripheral_enable_in,
			pin_peripheral_select_in) & f_sync[PFM_F8];
		cap_next[3] = alt_is(PFM_F6, PFM_ALT0, port_peripheral_enable_in,
			pin_peripheral_select_in) & f_sync[PFM_F6];
		pwm_next = pwm_out_in;
		if (alt_is(PFM_F4, PFM_ALT3, port_peripheral_enable_in, pin_peripheral_select_in)
				&& f_sync[PFM_F4]) begin
			pwm_next[PFM_FAULT_A] = 1'b0;
		end
		if (alt_is(PFM_F5, PFM_ALT3, port_peripheral_enable_in, pin_peripheral_select_in)
				&& f_sync[PFM_F5]) begin
			pwm_next[PFM_FAULT_B] = 1'b0;
		end
	end

	always_comb begin
		d_o[0] = dbg_data_in[0];
		d_oe[0] = dbg_dir_in[0] & ~dbg_peripheral_enable_in[0];
		d_o[1] = dbg_peripheral_enable_in[1] ? tdo_reg : dbg_data_in[1];
		d_oe[1] = dbg_peripheral_enable_in[1] ? tdo_en_reg : dbg_dir_in[1];
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			f_o_reg <= '0;
			f_oe_n_reg <= '1;
			f_pu_reg <= '1;
			d_o_reg <= '0;
			d_oe_n_reg <= 2'h3;
			d_pu_reg <= 2'h1;
			pwm_reg <= '0;
			cap_reg <= '0;
			mosi_reg <= 1'b0;
			ss_reg <= 1'b1;
			serial1_receive_reg <= 1'b1;
			rxd0_reg <= 1'b1;
			xbin_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			f_o_reg <= f_o;
			f_oe_n_reg <= ~f_oe;
			f_pu_reg <= f_port & ~dir_reg;
			d_o_reg <= d_o;
			d_oe_n_reg <= ~d_oe;
			d_pu_reg <= {1'b0, dbg_peripheral_enable_in[0] | ~dbg_dir_in[0]};
			pwm_reg <= pwm_next;
			cap_reg <= cap_next;
			mosi_reg <= mosi_next;
			ss_reg <= ss_next;
			serial1_receive_reg <= serial1_receive_next;
			rxd0_reg <= rxd0_next;
			xbin_reg <= xbin_next;
			irq_reg <= |f_pend;
		end
	end

	always_ff @(posedge test_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tdi_s1_reg <= 1'b1;
			tdi_reg <= 1'b1;
		end else begin
			tdi_s1_reg <= pad_d_in[0];
			tdi_reg <= tdi_s1_reg;
		end
	end

	always_ff @(negedge test_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tdo_reg <= 1'b0;
			tdo_en_reg <= 1'b0;
		end else begin
			tdo_reg <= test_data_out_in;
			tdo_en_reg <= (test_state_in == PFM_TST_SHIFT_IR) ||
				(test_state_in == PFM_TST_SHIFT_DR);
		end
	end

	assign pad_f_out = f_o_reg;
	assign pad_f_oe_n_out = f_oe_n_reg;
	assign pad_f_pullup_out = f_pu_reg;
	assign pad_d_out = d_o_reg;
	assign pad_d_oe_n_out = d_oe_n_reg;
	assign pad_d_pullup_out = d_pu_reg;
	assign test_data_in_out = tdi_reg;
	assign serperiph1_ctrl_out_periph_in_out = mosi_reg;
	assign serperiph1_select_n_out = ss_reg;
	assign serial1_receive_out = serial1_receive_reg;
	assign serial0_receive_out = rxd0_reg;
	assign pwm_capture_out = cap_reg;
	assign pwm_out_out = pwm_reg;
	assign crossbar_input_out = xbin_reg;
	assign port_read_out = f_sync;
	assign irq_pending_out = f_pend;
	assign irq_out = irq_reg;
endmodule // pfm_mux

// ===== tb/pfm_mux_monitor.sv
`timescale 1ns/1ps
module pfm_mux_monitor import pfm_pkg::*; (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Watched inputs
	input wire logic [5:0] port_peripheral_enable_in,
	input wire logic [11:0] pin_peripheral_select_in,
	input wire logic [5:0] pin_interrupt_enable_in,
	input wire logic [5:0] pad_f_in,
	input wire logic serperiph1_master_in,
	input wire logic [7:0] pwm_out_in,
	input wire logic [3:0] pwm_capture_mode_in,
	// Watched outputs
	input wire logic [5:0] pad_f_out,
	input wire logic [5:0] pad_f_oe_n_out,
	input wire logic [5:0] pad_f_pullup_out,
	input wire logic [1:0] pad_d_pullup_out,
	input wire logic serperiph1_select_n_out,
	input wire logic [7:0] pwm_out_out,
	input wire logic [5:0] port_read_out,
	input wire logic [5:0] irq_pending_out,
	input wire logic irq_out
);
	logic [1:0] settle_reg;
	logic [1:0] settle_next;

	// The synchroniser holds stale pad values for two edges after reset.
	always_comb begin
		settle_next = (settle_reg == 2'h3) ? settle_reg : settle_reg + 2'h1;
	end
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_reg <= 2'h0;
		end else begin
			settle_reg <= settle_next;
		end
	end

	default clocking @(posedge clk_in); endclocking

	sequence s_fault;
		(port_peripheral_enable_in[1] && pin_peripheral_select_in[3:2] == 2'h3 &&
			pad_f_in[1])[*5];
	endsequence
	sequence s_slave;
		(port_peripheral_enable_in[0] && pin_peripheral_select_in[1:0] == 2'h2 &&
			!serperiph1_master_in)[*3];
	endsequence

	reset_pull_a: assert property (!rst_n_in |-> &pad_f_oe_n_out &&
		&pad_f_pullup_out && pad_d_pullup_out == 2'h1) else $error("pads not pulled in reset");
	read_sync_a: assert property (disable iff (!rst_n_in) settle_reg == 2'h3 |->
		port_read_out == $past(pad_f_in, 2)) else $error("port read not two flops late");
	fault_block_a: assert property (disable iff (!rst_n_in) s_fault |->
		!pwm_out_out[6]) else $error("pwm output 6 active under fault");
	irq_gate_a: assert property (disable iff (!rst_n_in) $rose(irq_pending_out[2]) |->
		$past(!port_peripheral_enable_in[2] && pin_interrupt_enable_in[2]))
		else $error("pending set on a gated pin");
	irq_flop_a: assert property (disable iff (!rst_n_in)
		irq_out == $past(|irq_pending_out)) else $error("irq out not or of pending");
	spi_float_a: assert property (disable iff (!rst_n_in) s_slave |->
		pad_f_oe_n_out[0]) else $error("slave data pin driven");
	select_low_a: assert property (disable iff (!rst_n_in) (port_peripheral_enable_in[4] &&
		pin_peripheral_select_in[9:8] == 2'h1 && !pad_f_in[4])[*5] |-> !serperiph1_select_n_out)
		else $error("select low not passed");
	pwm_route_a: assert property (disable iff (!rst_n_in) (port_peripheral_enable_in[3] &&
		pin_peripheral_select_in[7:6] == 2'h0 && !pwm_capture_mode_in[3] && pwm_out_in[3])[*3]
		|-> pad_f_out[3] && !pad_f_oe_n_out[3]) else $error("pwm not routed to pin");
endmodule // pfm_mux_monitor

bind pfm_mux pfm_mux_monitor mon_u (.*);

// ===== tb/pfm_periph_model.sv
`timescale 1ns/1ps
module pfm_periph_model import pfm_pkg::*; (
	// Frame control from the bench
	input wire logic run_in,
	input wire logic shift_in,
	// Test controller side
	output logic test_clk_out,
	output logic [1:0] test_state_out,
	output logic test_data_out_out
);
	initial begin
		test_clk_out = 1'b0;
		test_state_out = PFM_TST_IDLE;
		test_data_out_out = 1'b0;
	end
	// The test clock stands low between frames and has no phase tie to the bus clock.
	always begin
		#37;
		test_clk_out = run_in ? ~test_clk_out : 1'b0;
	end
	// Shifting alternates between instruction and data paths so both states are exercised.
	always @(negedge test_clk_out) begin
		if (!shift_in) begin
			test_state_out <= PFM_TST_IDLE;
		end else if (test_state_out == PFM_TST_SHIFT_DR) begin
			test_state_out <= PFM_TST_SHIFT_IR;
		end else begin
			test_state_out <= PFM_TST_SHIFT_DR;
		end
	end
	always @(posedge test_clk_out) begin
		test_data_out_out <= ~test_data_out_out;
	end
endmodule // pfm_periph_model

// ===== tb/pin_function_mux_gpio_tb.sv
`timescale 1ns/1ps
module pin_function_mux_gpio_tb import pfm_pkg::*;;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b1;
	logic tst_shift = 1'b0;
	logic [5:0] port_peripheral_enable_in, dir_wr_in, dir_val_in, data_wr_in, data_val_in;
	logic [5:0] pin_interrupt_enable_in, pin_interrupt_polarity_in, irq_clear_in, pad_f_in;
	logic [5:0] pad_f_out, pad_f_oe_n_out, pad_f_pullup_out, port_read_out, irq_pending_out;
	logic [11:0] pin_peripheral_select_in;
	logic [1:0] dbg_peripheral_enable_in, dbg_dir_in, dbg_data_in, pad_d_in, test_state_in;
	logic [1:0] pad_d_out, pad_d_oe_n_out, pad_d_pullup_out;
	logic test_clk_in, test_data_out_in, test_data_in_out, twowire0_data_low_in;
	logic serperiph1_master_in, serperiph1_data_in, serperiph1_ctrl_out_periph_in_out;
	logic serperiph1_select_n_out, serial1_transmit_in, serial1_single_wire_in;
	logic serial1_tx_enable_in, serial1_receive_out, serial0_receive_out, irq_out;
	logic comparator_c_output_in, comparator_d_output_in, run, shift, tdo_hold;
	logic [10:7] crossbar_out_in;
	logic [7:0] pwm_out_in, pwm_out_out;
	logic [3:0] pwm_capture_mode_in, pwm_capture_out;
	logic [3:2] crossbar_input_out;
	int bad_count = 0;
	int cmp_count = 0;

	pfm_mux dut_u (.*);
	pfm_periph_model model_u (.run_in(run), .shift_in(shift), .test_clk_out(test_clk_in),
		.test_state_out(test_state_in), .test_data_out_out(test_data_out_in));

	always #4 clk_in = ~clk_in;

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// The tester samples at the rise, so the value seen then must be the one set at the fall.
	always @(negedge test_clk_in) begin
		tst_shift = (test_state_in == PFM_TST_SHIFT_IR) || (test_state_in == PFM_TST_SHIFT_DR);
		#20 tdo_hold = pad_d_out[1];
	end
	always @(posedge test_clk_in) begin
		if (pad_d_oe_n_out[1] === 1'b0) chk("tdo", tdo_hold, pad_d_out[1]);
		if (pad_d_oe_n_out[1] === 1'b0) chk("tdo val", 12'(test_data_out_in), pad_d_out[1]);
		if (dbg_peripheral_enable_in[1]) chk("tdo en", 12'(!tst_shift), pad_d_oe_n_out[1]);
	end

	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end

	initial begin
		// Reset falls as an event at time zero so the asynchronous flops see it.
		rst_n_in <= 1'b0;
		{port_peripheral_enable_in, dir_wr_in, dir_val_in, data_wr_in, data_val_in} = '0;
		{pin_interrupt_enable_in, pin_interrupt_polarity_in, irq_clear_in} = '0;
		{pin_peripheral_select_in, pwm_out_in, pwm_capture_mode_in, crossbar_out_in} = '0;
		{dbg_dir_in, dbg_data_in, run, shift, twowire0_data_low_in} = '0;
		{serperiph1_master_in, serperiph1_data_in, serial1_single_wire_in} = '0;
		{comparator_c_output_in, comparator_d_output_in} = '0;
		{serial1_transmit_in, serial1_tx_enable_in} = 2'h3;
		dbg_peripheral_enable_in = 2'h3;
		pad_f_in = 6'h3f;
		pad_d_in = 2'h1;
		cyc(8);
		chk("oe_n rst", 12'h03f, pad_f_oe_n_out);
		chk("pull rst", 12'h03f, pad_f_pullup_out);
		chk("dpull rst", 12'h001, pad_d_pullup_out);
		cyc(8);
		rst_n_in <= 1'b1;
		cyc(4);
		chk("oe_n idle", 12'h03f, pad_f_oe_n_out);
		chk("read", 12'h03f, port_read_out);
		chk("tdi in", 12'h001, pad_d_oe_n_out[0]);
		for (int i = 0; i < 6; i++) begin
			dir_wr_in <= 6'h01 << i;
			data_wr_in <= 6'h01 << i;
			dir_val_in <= 6'h3f;
			data_val_in <= 6'h15;
			cyc(1);
			{dir_wr_in, data_wr_in, dir_val_in, data_val_in} <= '0;
			cyc(2);
			chk("dir", (12'h03f << (i + 1)) & 12'h03f, pad_f_oe_n_out);
			chk("data", 12'h015 & ((12'h002 << i) - 12'h001), pad_f_out & ((6'h02 << i) - 6'h01));
		end
		dir_wr_in <= 6'h3f;
		cyc(1);
		dir_wr_in <= 6'h00;
		pin_interrupt_enable_in <= 6'h04;
		pad_f_in[2] <= 1'b0;
		cyc(5);
		chk("no rise", 12'h000, irq_pending_out);
		pad_f_in[2] <= 1'b1;
		cyc(2);
		pad_f_in[2] <= 1'b0;
		cyc(2);
		chk("pend", 12'h004, irq_pending_out);
		cyc(1);
		chk("irq", 12'h001, irq_out);
		irq_clear_in <= 6'h04;
		pin_interrupt_polarity_in <= 6'h04;
		cyc(1);
		irq_clear_in <= 6'h00;
		pad_f_in[2] <= 1'b1;
		cyc(5);
		chk("pol rise", 12'h000, irq_pending_out);
		pad_f_in[2] <= 1'b0;
		cyc(5);
		chk("pol fall", 12'h004, irq_pending_out);
		irq_clear_in <= 6'h04;
		port_peripheral_enable_in <= 6'h04;
		cyc(1);
		irq_clear_in <= 6'h00;
		pad_f_in[2] <= 1'b1;
		cyc(3);
		pad_f_in[2] <= 1'b0;
		cyc(5);
		chk("gated", 12'h000, irq_pending_out);
		pin_interrupt_enable_in <= 6'h00;
		port_peripheral_enable_in <= 6'h02;
		for (int c = 0; c < 4; c++) begin
			pin_peripheral_select_in <= 12'(c) << 2;
			serial1_transmit_in <= (c == 0);
			crossbar_out_in[8] <= (c == 1);
			pwm_out_in[0] <= (c == 2);
			cyc(4);
			chk("f4 oe", 12'(c == 3), pad_f_oe_n_out[1]);
			if (c < 3) chk("f4 out", 12'h001, pad_f_out[1]);
		end
		port_peripheral_enable_in <= 6'h06;
		pin_peripheral_select_in <= 12'h03c;
		pwm_out_in <= 8'hff;
		pad_f_in[2:1] <= 2'h3;
		cyc(5);
		chk("fault", 12'h03f, pwm_out_out);
		pad_f_in[2:1] <= 2'h0;
		cyc(5);
		chk("nofault", 12'h0ff, pwm_out_out);
		port_peripheral_enable_in <= 6'h08;
		pin_peripheral_select_in <= 12'h000;
		cyc(4);
		chk("pwm3", 12'h001, pad_f_out[3]);
		pwm_capture_mode_in <= 4'h8;
		pad_f_in[3] <= 1'b1;
		cyc(5);
		chk("cap oe", 12'h001, pad_f_oe_n_out[3]);
		chk("cap", 12'h001, pwm_capture_out[3]);
		port_peripheral_enable_in <= 6'h11;
		pin_peripheral_select_in <= 12'h102;
		serperiph1_master_in <= 1'b1;
		serperiph1_data_in <= 1'b1;
		cyc(4);
		chk("mst oe", 12'h000, pad_f_oe_n_out[0]);
		chk("mst out", 12'h001, pad_f_out[0]);
		serperiph1_master_in <= 1'b0;
		pad_f_in[4] <= 1'b0;
		cyc(5);
		chk("slv oe", 12'h001, pad_f_oe_n_out[0]);
		chk("slv in", 12'h001, serperiph1_ctrl_out_periph_in_out);
		chk("sel", 12'h000, serperiph1_select_n_out);
		pad_f_in[4] <= 1'b1;
		cyc(5);
		chk("unsel", 12'h001, serperiph1_select_n_out);
		port_peripheral_enable_in <= 6'h3b;
		pin_peripheral_select_in <= 12'h240;
		{serial1_single_wire_in, serial1_tx_enable_in, twowire0_data_low_in} <= 3'h5;
		pad_f_in[5] <= 1'b0;
		cyc(5);
		chk("share oe", 12'h03e, pad_f_oe_n_out);
		chk("od low", 12'h000, pad_f_out[0]);
		chk("rx share", 12'h000, serial1_receive_out);
		chk("rx0", 12'h000, serial0_receive_out);
		chk("xbar in", 12'h003, crossbar_input_out);
		chk("pull port", 12'h004, pad_f_pullup_out);
		chk("tdi pull", 12'h001, pad_d_pullup_out);
		{serial1_transmit_in, serial1_tx_enable_in} <= 2'h3;
		cyc(3);
		chk("tx drive", 12'h03c, pad_f_oe_n_out);
		chk("tx out", 12'h002, pad_f_out & 6'h03);
		{run, shift} <= 2'h3;
		cyc(60);
		chk("tdo on", 12'h000, pad_d_oe_n_out[1]);
		chk("tdi", 12'h001, test_data_in_out);
		pad_d_in[0] <= 1'b0;
		shift <= 1'b0;
		cyc(60);
		chk("tdi low", 12'h000, test_data_in_out);
		chk("tdo off", 12'h001, pad_d_oe_n_out[1]);
		run <= 1'b0;
		dbg_peripheral_enable_in <= 2'h0;
		dbg_dir_in <= 2'h2;
		dbg_data_in <= 2'h2;
		cyc(4);
		chk("d gpio", 12'h001, pad_d_oe_n_out);
		chk("d out", 12'h001, pad_d_out[1]);
		wrap_up();
	end
endmodule // pin_function_mux_gpio_tb
